//--- bench/motor_pad_model.sv
// Purpose: Motor pin level. Assumes: undriven pins toggle every clock. Notes: none.
`timescale 1ns/10ps
`default_nettype none
module motor_pad_model (
   input wire logic mclk_i,
   input wire logic [3:0] motor_i,
   input wire logic [3:0] motor_oe_i,
   output logic [3:0] pad_o
);
   logic [3:0] last = 4'h0;
   always @(posedge mclk_i) last <= pad_o;
   assign pad_o = (motor_oe_i & motor_i) | (~motor_oe_i & ~last);
endmodule : motor_pad_model
`default_nettype wire

//--- bench/scan_cfg_bank_tb.sv
// Purpose: Self-checking bench. Assumes: one clock. Notes: queued checks.
`timescale 1ns/10ps
`default_nettype none
module scan_cfg_bank_tb;
   import scan_cfg_pkg::*;
   logic mclk_i, srst_i, rd, wr, wt, pv, pvo, ld, kp, tp, ms;
   logic [7:0] adr, dc;
   logic [31:0] wd, rdo, lf, r, rq[$], pq[$];
   logic [3:0] be, ph, mo, moe, pad;
   logic [15:0] pix, dg, dof, pxo, offr, gainr;
   logic [19:0] lim;
   int bad_count, n_compared, k;
   scan_cfg_bank u_dut (.mclk_i(mclk_i), .srst_i(srst_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdo),
      .avs_waitrequest_o(wt), .pixel_i(pix), .pixel_valid_i(pv),
      .dram_gain_i(dg), .dram_offset_i(dof), .line_done_i(ld),
      .phase_on_i(ph), .pixel_o(pxo), .pixel_valid_o(pvo),
      .keep_line_o(kp), .dram_limit_o(lim), .two_phase_sense_o(tp),
      .microstep_o(ms), .motor_o(mo), .motor_oe_o(moe));
   motor_pad_model u_pad (.mclk_i(mclk_i), .motor_i(mo),
      .motor_oe_i(moe), .pad_o(pad));
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      do @(posedge mclk_i); while (wt !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge mclk_i);
   endtask : bus
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rchk
   task automatic px();
      logic [15:0] o, g;
      lf = nxt(lf);
      pix <= lf[31:16];
      dg <= lf[23:8];
      dof <= {4'h0, lf[11:0]};
      o = dc[BIT_OFFSET_SRC] ? {4'h0, lf[11:0]} : offr;
      g = dc[BIT_GAIN_SRC] ? lf[23:8] : gainr;
      r = (lf[31:16] > o) ? 32'(lf[31:16] - o) : 32'h0;
      if (!dc[BIT_SHADE_BYPASS]) r = (r * g) >> GAIN_SHIFT;
      pq.push_back((r > 32'hFFFF) ? 32'hFFFF : r);
      pv <= 1'b1;
      @(posedge mclk_i);
   endtask : px
   task automatic lines(input logic [7:0] t, m, input int e);
      int c = 0;
      bus(1'b1, IDX_SKIP_KEEP, {24'h0, t});
      bus(1'b1, IDX_SKIP_GROUP, {24'h0, m});
      repeat (8) begin
         c += (kp === 1'b1);
         ld <= 1'b1;
         @(posedge mclk_i);
         ld <= 1'b0;
         repeat (2) @(posedge mclk_i);
      end
      chk("kept", e, c);
   endtask : lines
   task automatic final_report();
      if (bad_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
   always @(posedge mclk_i) begin
      if (rd && wt === 1'b0) chk("readdata", rq.pop_front(), rdo);
      if (pvo === 1'b1) chk("pixel", pq.pop_front(), {16'h0, pxo});
   end
   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end
   initial begin
      repeat (20000) @(posedge mclk_i);
      bad_count++;
      final_report();
   end
   initial begin
      {srst_i, rd, wr, pv, ld, adr, wd, ph, pix, dg, dof} = 97'h0;
      srst_i = 1'b1;
      be = 4'hF;
      lf = 32'h97170292;
      repeat (20) @(posedge mclk_i);
      srst_i <= 1'b0;
      for (k = 0; k < 8; k++) begin
         rchk(8'(IDX_OFFSET_HIGH + k), (k == 4) ? 32'h20 : 32'h0);
         lf = nxt(lf);
         r = {24'h0, (k == 4) ? (lf[7:0] & 8'h47) | 8'h20 :
            (k == 7) ? lf[7:0] & 8'h13 : lf[7:0]};
         bus(1'b1, 8'(IDX_OFFSET_HIGH + k), r);
         rchk(8'(IDX_OFFSET_HIGH + k), r);
      end
      be <= 4'h0;
      bus(1'b1, IDX_MOTOR_CTRL, 32'h0);
      be <= 4'hF;
      rchk(IDX_MOTOR_CTRL, r);
      bus(1'b1, 8'h10, 32'hFF);
      rchk(8'h10, READ_UNMAPPED);
      for (k = 0; k < 8; k++) begin
         lf = nxt(lf);
         offr = {4'h0, lf[11:0]};
         gainr = lf[31:16];
         dc = {1'b0, k[0], 3'b100, k[2:0]};
         bus(1'b1, IDX_DRAM_CTRL, {24'h0, dc});
         bus(1'b1, IDX_OFFSET_HIGH, {24'h0, offr[15:8]});
         bus(1'b1, IDX_OFFSET_LOW, {24'h0, offr[7:0]});
         bus(1'b1, IDX_GAIN_HIGH, {24'h0, gainr[15:8]});
         bus(1'b1, IDX_GAIN_LOW, {24'h0, gainr[7:0]});
         repeat (6) px();
         pv <= 1'b0;
         repeat (3) @(posedge mclk_i);
      end
      for (k = 0; k < 4; k++) begin
         bus(1'b1, IDX_MOTOR_CTRL, {27'h0, 1'b1, k[1:0], 2'b11});
         lf = nxt(lf);
         ph <= lf[3:0];
         repeat (3) @(posedge mclk_i);
         chk("pad", {28'h0, lf[3:0] ^ {2{k[1:0]}}}, {28'h0, pad});
         chk("mode", 32'h3, {30'h0, tp, ms});
      end
      bus(1'b1, IDX_MOTOR_CTRL, 32'h0);
      repeat (2) @(posedge mclk_i);
      chk("drive", 32'h0, {28'h0, moe});
      chk("mode", 32'h0, {30'h0, tp, ms});
      srst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      srst_i <= 1'b0;
      lines(8'hFE, 8'h04, 4);
      lines(8'h00, 8'h04, 8);
      rchk(IDX_LINE_STATUS, 32'h3);
      lines(8'hFE, 8'h00, 8);
      repeat (2) @(posedge mclk_i);
      chk("queued", 32'h0, rq.size() + pq.size());
      final_report();
   end
endmodule : scan_cfg_bank_tb
`default_nettype wire

//--- bench/scan_cfg_properties.sv
// Purpose: Bus and motor checks. Assumes: one clock. Notes: bound below.
`timescale 1ns/10ps
`default_nettype none
module scan_cfg_checker
   import scan_cfg_pkg::*;
(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic [3:0] phase_on_i,
   input wire logic [19:0] dram_limit_o,
   input wire logic two_phase_sense_o,
   input wire logic microstep_o,
   input wire logic [3:0] motor_o,
   input wire logic [3:0] motor_oe_o
);
   logic [7:0] mc, dc;
   logic [3:0] pol;
   logic wok;
   assign wok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   assign pol = {2{mc[BIT_POL_B], mc[BIT_POL_A]}};
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         mc <= RST_ZERO;
         dc <= RST_DRAM_CTRL;
      end else if (wok && avs_address_i == IDX_MOTOR_CTRL) begin
         mc <= avs_writedata_i[7:0];
      end else if (wok && avs_address_i == IDX_DRAM_CTRL) begin
         dc <= avs_writedata_i[7:0];
      end
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   property p_ack;
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   a_ack: assert property (p_ack) else $error("no answer");
   property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
   a_one: assert property (p_one) else $error("long answer");
   property p_hi;
      !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0;
   endproperty
   a_hi: assert property (p_hi) else $error("upper bits");
   property p_pol;
      !$past(srst_i) && $stable(pol) |-> motor_o == ($past(phase_on_i) ^ pol);
   endproperty
   a_pol: assert property (p_pol) else $error("polarity");
   property p_oe;
      $stable(mc) |-> motor_oe_o == {4{mc[BIT_MOTOR_ON]}};
   endproperty
   a_oe: assert property (p_oe) else $error("drive enable");
   property p_ms; $stable(mc) |-> microstep_o == mc[BIT_MICROSTEP]; endproperty
   a_ms: assert property (p_ms) else $error("step mode");
   property p_tp;
      $stable(mc) |-> two_phase_sense_o == mc[BIT_SENSE_TWO];
   endproperty
   a_tp: assert property (p_tp) else $error("sense phases");
   property p_lim; $stable(dc) |-> dram_limit_o ==
      (dc[BIT_DRAM_SIZE] ? DRAM_LIMIT_LARGE : DRAM_LIMIT_SMALL); endproperty
   a_lim: assert property (p_lim) else $error("dram range");
endmodule : scan_cfg_checker
bind scan_cfg_bank scan_cfg_checker u_chk (.*);
`default_nettype wire

//--- core/line_skip_gate.sv
// Purpose: Decides per scanned line whether it is kept under n out of m.
// Assumes: One line_done_i pulse per scanned line.
// Notes: Counts kept and scanned lines inside each group of m.
`timescale 1ns/10ps
`default_nettype none
module line_skip_gate
   import scan_cfg_pkg::*;
(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic [7:0] keep_t_i,
   input wire logic [7:0] group_m_i,
   input wire logic line_done_i,
   output logic keep_line_o,
   output logic bypass_o
);
   logic [7:0] scanned;
   logic [8:0] kept;
   logic [7:0] next_scanned;
   logic [8:0] next_kept;
   logic [8:0] keep_n;
   logic byp;

   always_comb begin
      keep_n = SKIP_BASE - {1'b0, keep_t_i};
      byp = (keep_t_i == RST_ZERO) || (group_m_i == RST_ZERO);
      next_scanned = scanned;
      next_kept = kept;
      if (byp) begin
         next_scanned = RST_ZERO;
         next_kept = 9'h000;
      end else if (line_done_i) begin
         if (kept < keep_n) begin
            next_kept = kept + 9'h001;
         end
         if (scanned + 8'h01 >= group_m_i) begin
            next_scanned = RST_ZERO;
            next_kept = 9'h000;
         end else begin
            next_scanned = scanned + 8'h01;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         scanned <= RST_ZERO;
         kept <= 9'h000;
      end else begin
         scanned <= next_scanned;
         kept <= next_kept;
      end
   end

   assign keep_line_o = byp || (kept < keep_n);
   assign bypass_o = byp;
endmodule : line_skip_gate
`default_nettype wire

//--- core/scan_cfg_bank.sv
// Purpose: Register bank for pixel correction, line skip and motor drive.
// Assumes: Single clock; Avalon-MM slave answers in one wait cycle.
// Notes: Motor pins are split into output and output enable.
// Functional notes
// - Hold 16-bit fixed offset, high then low.
// - Hold 16-bit fixed gain, high then low.
// - Gain bit zero scales by coefficient/16384.
// - Gain source selects fixed or DRAM.
// - Offset source selects fixed or DRAM.
// - Keep 256 minus t lines; t zero bypasses.
// - Group m lines; m zero bypasses.
// - Sense one phase or two phases.
// - Phase A polarity high or low active.
// - Phase B polarity high or low active.
// - Motor status off tri-states all phases.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module scan_cfg_bank
   import scan_cfg_pkg::*;
#(
   parameter int PIX_W = 16
) (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [PIX_W-1:0] pixel_i,
   input wire logic pixel_valid_i,
   input wire logic [15:0] dram_gain_i,
   input wire logic [15:0] dram_offset_i,
   input wire logic line_done_i,
   input wire logic [3:0] phase_on_i,
   output logic [PIX_W-1:0] pixel_o,
   output logic pixel_valid_o,
   output logic keep_line_o,
   output logic [19:0] dram_limit_o,
   output logic two_phase_sense_o,
   output logic microstep_o,
   output logic [3:0] motor_o,
   output logic [3:0] motor_oe_o
);
   // ****************************************************************
   // Register storage.
   // ****************************************************************
   logic [7:0] off_hi;
   logic [7:0] off_lo;
   logic [7:0] gain_hi;
   logic [7:0] gain_lo;
   logic [7:0] dram_ctrl;
   logic [7:0] skip_keep;
   logic [7:0] skip_group;
   logic [7:0] motor_ctrl;
   logic [7:0] next_off_hi;
   logic [7:0] next_off_lo;
   logic [7:0] next_gain_hi;
   logic [7:0] next_gain_lo;
   logic [7:0] next_dram_ctrl;
   logic [7:0] next_skip_keep;
   logic [7:0] next_skip_group;
   logic [7:0] next_motor_ctrl;
   logic ack;
   logic next_ack;
   logic next_wait;
   logic rd_new;
   logic wr_ok;
   logic [31:0] next_rdata;
   logic skip_keep_line;
   logic skip_bypass;

   // ****************************************************************
   // Bus handshake.
   // ****************************************************************
   always_comb begin
      next_ack = (avs_read_i || avs_write_i) && !ack;
      next_wait = !next_ack;
      rd_new = avs_read_i && !ack;
      wr_ok = avs_write_i && ack && avs_byteenable_i[0];
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         ack <= 1'b0;
         avs_waitrequest_o <= 1'b1;
      end else begin
         ack <= next_ack;
         avs_waitrequest_o <= next_wait;
      end
   end

   // ****************************************************************
   // Register writes.
   // ****************************************************************
   always_comb begin
      next_off_hi = off_hi;
      next_off_lo = off_lo;
      next_gain_hi = gain_hi;
      next_gain_lo = gain_lo;
      next_dram_ctrl = dram_ctrl;
      next_skip_keep = skip_keep;
      next_skip_group = skip_group;
      next_motor_ctrl = motor_ctrl;
      if (wr_ok) begin
         case (avs_address_i)
            IDX_OFFSET_HIGH: begin
               next_off_hi = avs_writedata_i[7:0];
            end
            IDX_OFFSET_LOW: begin
               next_off_lo = avs_writedata_i[7:0];
            end
            IDX_GAIN_HIGH: begin
               next_gain_hi = avs_writedata_i[7:0];
            end
            IDX_GAIN_LOW: begin
               next_gain_lo = avs_writedata_i[7:0];
            end
            IDX_DRAM_CTRL: begin
               next_dram_ctrl = avs_writedata_i[7:0];
            end
            IDX_SKIP_KEEP: begin
               next_skip_keep = avs_writedata_i[7:0];
            end
            IDX_SKIP_GROUP: begin
               next_skip_group = avs_writedata_i[7:0];
            end
            IDX_MOTOR_CTRL: begin
               next_motor_ctrl = avs_writedata_i[7:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         off_hi <= RST_ZERO;
         off_lo <= RST_ZERO;
         gain_hi <= RST_ZERO;
         gain_lo <= RST_ZERO;
         dram_ctrl <= RST_DRAM_CTRL;
         skip_keep <= RST_ZERO;
         skip_group <= RST_ZERO;
         motor_ctrl <= RST_ZERO;
      end else begin
         off_hi <= next_off_hi;
         off_lo <= next_off_lo;
         gain_hi <= next_gain_hi;
         gain_lo <= next_gain_lo;
         dram_ctrl <= next_dram_ctrl;
         skip_keep <= next_skip_keep;
         skip_group <= next_skip_group;
         motor_ctrl <= next_motor_ctrl;
      end
   end

   // ****************************************************************
   // Register reads.
   // ****************************************************************
   always_comb begin
      next_rdata = READ_UNMAPPED;
      if (rd_new) begin
         case (avs_address_i)
            IDX_OFFSET_HIGH: begin
               next_rdata = {24'h000000, off_hi};
            end
            IDX_OFFSET_LOW: begin
               next_rdata = {24'h000000, off_lo};
            end
            IDX_GAIN_HIGH: begin
               next_rdata = {24'h000000, gain_hi};
            end
            IDX_GAIN_LOW: begin
               next_rdata = {24'h000000, gain_lo};
            end
            IDX_DRAM_CTRL: begin
               next_rdata = {24'h000000, dram_ctrl};
            end
            IDX_SKIP_KEEP: begin
               next_rdata = {24'h000000, skip_keep};
            end
            IDX_SKIP_GROUP: begin
               next_rdata = {24'h000000, skip_group};
            end
            IDX_MOTOR_CTRL: begin
               next_rdata = {24'h000000, motor_ctrl};
            end
            IDX_LINE_STATUS: begin
               next_rdata = {30'h0, skip_bypass, skip_keep_line};
            end
            default: begin
               next_rdata = READ_UNMAPPED;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         avs_readdata_o <= READ_UNMAPPED;
      end else begin
         avs_readdata_o <= next_rdata;
      end
   end

   // ****************************************************************
   // Pixel correction.
   // ****************************************************************
   logic [15:0] use_gain, use_off;
   logic [PIX_W:0] sub_val;
   logic [PIX_W+16:0] prod;
   logic [PIX_W+16:0] scaled;
   logic [PIX_W-1:0] next_pixel;

   always_comb begin
      use_gain = dram_ctrl[BIT_GAIN_SRC] ? dram_gain_i
                                         : {gain_hi, gain_lo};
      use_off = dram_ctrl[BIT_OFFSET_SRC] ? dram_offset_i
                                          : {off_hi, off_lo};
      sub_val = {1'b0, pixel_i} - {1'b0, use_off[PIX_W-1:0]};
      if (sub_val[PIX_W]) begin
         sub_val = '0;
      end
      prod = {16'h0000, sub_val} * {{(PIX_W+1){1'b0}}, use_gain};
      scaled = prod >> GAIN_SHIFT;
      if (dram_ctrl[BIT_SHADE_BYPASS]) begin
         next_pixel = sub_val[PIX_W-1:0];
      end else if (|scaled[PIX_W+16:PIX_W]) begin
         next_pixel = '1;
      end else begin
         next_pixel = scaled[PIX_W-1:0];
      end
   end

   // ****************************************************************
   // Line skipping.
   // ****************************************************************
   line_skip_gate u_skip (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .keep_t_i(skip_keep),
      .group_m_i(skip_group),
      .line_done_i(line_done_i),
      .keep_line_o(skip_keep_line),
      .bypass_o(skip_bypass)
   );

   // ****************************************************************
   // Motor drive and output registers.
   // ****************************************************************
   wire logic [3:0] pol;
   wire logic [3:0] next_motor;
   wire logic [3:0] next_motor_oe;
   logic [19:0] next_limit;

   for (genvar ph = 0; ph < 4; ph++) begin : g_phase
      // Even phases follow winding A, odd phases follow winding B.
      assign pol[ph] = (ph % 2 == 0) ? motor_ctrl[BIT_POL_A]
                                     : motor_ctrl[BIT_POL_B];
      assign next_motor[ph] = phase_on_i[ph] ^ pol[ph];
      assign next_motor_oe[ph] = motor_ctrl[BIT_MOTOR_ON];
   end

   always_comb begin
      next_limit = dram_ctrl[BIT_DRAM_SIZE] ? DRAM_LIMIT_LARGE
                                            : DRAM_LIMIT_SMALL;
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         keep_line_o <= 1'b1;
         dram_limit_o <= DRAM_LIMIT_SMALL;
         two_phase_sense_o <= 1'b0;
         microstep_o <= 1'b0;
         motor_o <= 4'h0;
         motor_oe_o <= 4'h0;
      end else begin
         keep_line_o <= skip_keep_line;
         dram_limit_o <= next_limit;
         two_phase_sense_o <= motor_ctrl[BIT_SENSE_TWO];
         microstep_o <= motor_ctrl[BIT_MICROSTEP];
         motor_o <= next_motor;
         motor_oe_o <= next_motor_oe;
      end
   end

   // ****************************************************************
   // Pixel output register.
   // ****************************************************************
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         pixel_o <= '0;
         pixel_valid_o <= 1'b0;
      end else begin
         pixel_o <= next_pixel;
         pixel_valid_o <= pixel_valid_i;
      end
   end
endmodule : scan_cfg_bank
`default_nettype wire

//--- core/scan_cfg_pkg.sv
// Purpose: Constants for the scan correction and motor configuration bank.
// Assumes: Avalon-MM word addressing, one register per 32-bit word.
// Notes: Register indices are byte addresses divided by four.
package scan_cfg_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] IDX_OFFSET_HIGH = 8'h3E;
   localparam logic [7:0] IDX_OFFSET_LOW = 8'h3F;
   localparam logic [7:0] IDX_GAIN_HIGH = 8'h40;
   localparam logic [7:0] IDX_GAIN_LOW = 8'h41;
   localparam logic [7:0] IDX_DRAM_CTRL = 8'h42;
   localparam logic [7:0] IDX_SKIP_KEEP = 8'h43;
   localparam logic [7:0] IDX_SKIP_GROUP = 8'h44;
   localparam logic [7:0] IDX_MOTOR_CTRL = 8'h45;
   localparam logic [7:0] IDX_LINE_STATUS = 8'h46;
   localparam int BIT_SHADE_BYPASS = 0;
   localparam int BIT_GAIN_SRC = 1;
   localparam int BIT_OFFSET_SRC = 2;
   localparam int BIT_DRAM_SIZE = 6;
   localparam int BIT_MICROSTEP = 0;
   localparam int BIT_SENSE_TWO = 1;
   localparam int BIT_POL_A = 2;
   localparam int BIT_POL_B = 3;
   localparam int BIT_MOTOR_ON = 4;
   localparam logic [7:0] RST_DRAM_CTRL = 8'h20;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam int GAIN_SHIFT = 14;
   localparam logic [8:0] SKIP_BASE = 9'h100;
   localparam logic [19:0] DRAM_LIMIT_SMALL = 20'h3FFFF;
   localparam logic [19:0] DRAM_LIMIT_LARGE = 20'hFFFFF;
   localparam logic [31:0] READ_UNMAPPED = 32'h00000000;
endpackage : scan_cfg_pkg
